//--- design/aes_params.svh
`ifndef AES_PARAMS_SVH
`define AES_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define AES_OFS_ACT_PRIO      8'h0A
`define AES_OFS_REMARK_MAP    8'h0B
`define AES_OFS_SPARE         8'h0C
`define AES_OFS_FWD_PORTS     8'h0D
`define AES_OFS_RULESET_HI    8'h0E
`define AES_OFS_RULESET_LO    8'h0F
`define AES_OFS_BSEL_HI       8'h10
`define AES_OFS_BSEL_LO       8'h11
`define AES_OFS_STATUS        8'h13

// ----------------------------------------
// reset values
// ----------------------------------------
`define AES_RST_BYTE          8'h00
`define AES_RST_UNMAPPED      8'h00
`define AES_RST_DONE          1'b1

// ----------------------------------------
// field positions
// ----------------------------------------
`define AES_PHS_HI            7
`define AES_PHS_LO            6
`define AES_PRIO_HI           5
`define AES_PRIO_LO           3
`define AES_RPE_BIT           2
`define AES_RPRI_HI_HI        1
`define AES_RPRI_HI_LO        0
`define AES_RPRI_LSB_BIT      7
`define AES_FMS_HI            6
`define AES_FMS_LO            5
`define AES_FWD_HI            5
`define AES_FWD_LO            0
`define AES_STAT_RD_BIT       0
`define AES_STAT_WR_BIT       1
`define AES_STAT_BUSY_BIT     2

// ----------------------------------------
// staging byte numbering
// ----------------------------------------
`define AES_FIRST_ACTION_BYTE 10
`define AES_LAST_HIGH_BYTE    7
`define AES_LAST_BYTE         15

`endif

//--- design/aes_pkg.sv
package aes_pkg;

  // ----------------------------------------
  // request toward the entry table
  // ----------------------------------------
  typedef struct packed {
    logic        start;
    logic        write;
    logic [15:0] byte_sel;
    logic [47:0] wdata;
  } aes_tbl_req_t;

  // ----------------------------------------
  // answer from the entry table
  // ----------------------------------------
  typedef struct packed {
    logic        done;
    logic [47:0] rdata;
  } aes_tbl_rsp_t;

  // ----------------------------------------
  // decoded action fields
  // ----------------------------------------
  typedef struct packed {
    logic [1:0]  priority_handling_select;
    logic [2:0]  priority_value;
    logic        remark_priority_enable;
    logic [2:0]  remark_priority;
    logic [1:0]  forward_map_select;
    logic [5:0]  forward_ports;
    logic [15:0] ruleset;
  } aes_action_t;

  typedef enum logic [1:0] {
    AES_IDLE,
    AES_WAIT_RD,
    AES_WAIT_WR
  } aes_state_t;

endpackage : aes_pkg

//--- design/aes_byte_lane.sv
`timescale 1ns/100ps
`include "aes_params.svh"

// ----------------------------------------
// one staging byte, software or table load
// ----------------------------------------
module aes_byte_lane
  import aes_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = `AES_RST_BYTE
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sw_write,
  input  wire logic [7:0] sw_data,
  input  wire logic       tbl_load,
  input  wire logic [7:0] tbl_data,
  output logic      [7:0] q
);

  logic [7:0] next_q;

  // table load wins over a software write in the same cycle
  assign next_q = tbl_load ? tbl_data : (sw_write ? sw_data : q);

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RESET_VALUE;
    end else begin
      q <= next_q;
    end
  end

endmodule : aes_byte_lane

//--- design/aes_xfer_ctrl.sv
`timescale 1ns/100ps
`include "aes_params.svh"

// ----------------------------------------
// indirect transfer sequencing and status
// ----------------------------------------
module aes_xfer_ctrl
  import aes_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic write,
  input  wire logic done,
  output logic      busy,
  output logic      read_complete,
  output logic      write_complete,
  output logic      load_stage
);

  aes_state_t state;
  aes_state_t next_state;
  wire        start_ok = start && (state == AES_IDLE);
  wire        rd_finish = done && (state == AES_WAIT_RD);
  wire        wr_finish = done && (state == AES_WAIT_WR);

  always_comb begin
    next_state = state;
    case (state)
      AES_IDLE: begin
        if (start_ok) begin
          next_state = write ? AES_WAIT_WR : AES_WAIT_RD;
        end
      end
      AES_WAIT_RD: begin
        if (done) begin
          next_state = AES_IDLE;
        end
      end
      AES_WAIT_WR: begin
        if (done) begin
          next_state = AES_IDLE;
        end
      end
      default: begin
        next_state = AES_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state          <= AES_IDLE;
      read_complete  <= `AES_RST_DONE;
      write_complete <= `AES_RST_DONE;
      busy           <= 1'b0;
    end else begin
      state <= next_state;
      busy  <= (next_state != AES_IDLE);
      // zero while a read runs, one when it ends
      if (rd_finish) begin
        read_complete <= 1'b1;
      end else if (start_ok && !write) begin
        read_complete <= 1'b0;
      end
      // zero while a write is pending, one when it ends
      if (wr_finish) begin
        write_complete <= 1'b1;
      end else if (start_ok && write) begin
        write_complete <= 1'b0;
      end
    end
  end

  assign load_stage = rd_finish;

endmodule : aes_xfer_ctrl

//--- design/aes_staging_regs.sv
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "aes_params.svh"

// Overview of operation
// - The remark priority enable is a read-write bit at bit 2 of the priority byte, reset to zero.
// - The remark priority is priority byte bits 1:0 on top and remark byte bit 7 as its lowest bit.
// - A six-bit forward map holds one bit per port, bit 0 for port 1, set to forward, clear to block.
// - A write to the low byte-select register starts the transfer; software sets the high one first.
// - High byte-select bit 0 picks staging byte 7 and bit 7 picks staging byte 0.
// - Low byte-select bit 0 picks staging byte 15 and bit 7 picks staging byte 8.
// - Only enabled bytes move in a transfer; disabled bytes stay as they are on both sides.
// - Read-complete reads zero while a table read runs and one when it ends, for software to poll.
// - Write-complete reads zero while a table write is pending and one once it has finished.
module aes_staging_regs
  import aes_pkg::*;
#(
  parameter int ADDR_W  = 8,
  parameter int N_BYTES = 6
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [7:0]        reg_rdata,
  input  wire logic              xfer_write,
  output aes_tbl_req_t           tbl_req,
  input  wire aes_tbl_rsp_t      tbl_rsp,
  output aes_action_t            action,
  output logic                   read_complete,
  output logic                   write_complete
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire hit_prio    = (reg_addr == ADDR_W'(`AES_OFS_ACT_PRIO));
  wire hit_remark  = (reg_addr == ADDR_W'(`AES_OFS_REMARK_MAP));
  wire hit_spare   = (reg_addr == ADDR_W'(`AES_OFS_SPARE));
  wire hit_fwd     = (reg_addr == ADDR_W'(`AES_OFS_FWD_PORTS));
  wire hit_rs_hi   = (reg_addr == ADDR_W'(`AES_OFS_RULESET_HI));
  wire hit_rs_lo   = (reg_addr == ADDR_W'(`AES_OFS_RULESET_LO));
  wire hit_bsel_hi = (reg_addr == ADDR_W'(`AES_OFS_BSEL_HI));
  wire hit_bsel_lo = (reg_addr == ADDR_W'(`AES_OFS_BSEL_LO));
  wire hit_status  = (reg_addr == ADDR_W'(`AES_OFS_STATUS));

  wire [N_BYTES-1:0] stage_hit = {hit_prio, hit_remark, hit_spare,
                                  hit_fwd, hit_rs_hi, hit_rs_lo};

  // ----------------------------------------
  // byte-select registers
  // ----------------------------------------
  logic [7:0]  bsel_hi;
  logic [7:0]  bsel_lo;
  logic [15:0] byte_en;
  logic        busy;
  logic        load_stage;
  logic        xfer_start;
  logic        rd_done;
  logic        wr_done;

  always_ff @(posedge clk) begin
    if (rst) begin
      bsel_hi <= `AES_RST_BYTE;
      bsel_lo <= `AES_RST_BYTE;
    end else begin
      if (reg_write && hit_bsel_hi) begin
        bsel_hi <= reg_wdata;
      end
      if (reg_write && hit_bsel_lo) begin
        bsel_lo <= reg_wdata;
      end
    end
  end

  // low byte-select write is the start strobe
  assign xfer_start = reg_write && hit_bsel_lo;

  // ----------------------------------------
  // select bits to staging bytes, reversed
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi <= `AES_LAST_HIGH_BYTE; gi = gi + 1) begin : g_en_hi
      assign byte_en[gi] = bsel_hi[`AES_LAST_HIGH_BYTE - gi];
    end
    for (gi = `AES_LAST_HIGH_BYTE + 1; gi <= `AES_LAST_BYTE; gi = gi + 1) begin : g_en_lo
      assign byte_en[gi] = bsel_lo[`AES_LAST_BYTE - gi];
    end
  endgenerate

  // ----------------------------------------
  // transfer sequencing
  // ----------------------------------------
  aes_xfer_ctrl u_ctrl (
    .clk            (clk),
    .rst            (rst),
    .start          (xfer_start),
    .write          (xfer_write),
    .done           (tbl_rsp.done),
    .busy           (busy),
    .read_complete  (rd_done),
    .write_complete (wr_done),
    .load_stage     (load_stage)
  );

  // ----------------------------------------
  // captured selection of the running transfer
  // ----------------------------------------
  logic [15:0] run_en;
  wire         start_taken = xfer_start && !busy;
  // the low select register lands this cycle, so take it from the bus
  wire [15:0]  start_en;

  generate
    for (gi = 0; gi <= `AES_LAST_HIGH_BYTE; gi = gi + 1) begin : g_st_hi
      assign start_en[gi] = byte_en[gi];
    end
    for (gi = `AES_LAST_HIGH_BYTE + 1; gi <= `AES_LAST_BYTE; gi = gi + 1) begin : g_st_lo
      assign start_en[gi] = reg_wdata[`AES_LAST_BYTE - gi];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      run_en <= 16'h0000;
    end else if (start_taken) begin
      run_en <= start_en;
    end
  end

  // ----------------------------------------
  // staging bytes of the action half
  // ----------------------------------------
  logic [7:0] stage [N_BYTES];
  wire  [47:0] stage_flat = {stage[5], stage[4], stage[3], stage[2], stage[1], stage[0]};

  generate
    for (gi = 0; gi < N_BYTES; gi = gi + 1) begin : g_lane
      // lane gi is staging byte 15-gi; lane 5 is the priority byte
      localparam int BYTE_NO = `AES_LAST_BYTE - gi;
      wire lane_load = load_stage && run_en[BYTE_NO];
      aes_byte_lane #(
        .RESET_VALUE (`AES_RST_BYTE)
      ) u_lane (
        .clk      (clk),
        .rst      (rst),
        .sw_write (reg_write && stage_hit[gi]),
        .sw_data  (reg_wdata),
        .tbl_load (lane_load),
        .tbl_data (tbl_rsp.rdata[gi*8 +: 8]),
        .q        (stage[gi])
      );
    end
  endgenerate

  wire [7:0] byte_prio   = stage[5];
  wire [7:0] byte_remark = stage[4];
  wire [7:0] byte_spare  = stage[3];
  wire [7:0] byte_fwd    = stage[2];
  wire [7:0] byte_rs_hi  = stage[1];
  wire [7:0] byte_rs_lo  = stage[0];

  // ----------------------------------------
  // request toward the table
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tbl_req <= '0;
    end else begin
      tbl_req.start <= start_taken;
      if (start_taken) begin
        tbl_req.write    <= xfer_write;
        tbl_req.byte_sel <= start_en;
        tbl_req.wdata    <= stage_flat;
      end
    end
  end

  // ----------------------------------------
  // action fields; reserved bits go nowhere
  // ----------------------------------------
  aes_action_t next_action;

  always_comb begin
    next_action = '0;
    next_action.priority_handling_select = byte_prio[`AES_PHS_HI:`AES_PHS_LO];
    next_action.priority_value           = byte_prio[`AES_PRIO_HI:`AES_PRIO_LO];
    next_action.remark_priority_enable   = byte_prio[`AES_RPE_BIT];
    next_action.remark_priority          = {byte_prio[`AES_RPRI_HI_HI:`AES_RPRI_HI_LO],
                                            byte_remark[`AES_RPRI_LSB_BIT]};
    next_action.forward_map_select       = byte_remark[`AES_FMS_HI:`AES_FMS_LO];
    next_action.forward_ports            = byte_fwd[`AES_FWD_HI:`AES_FWD_LO];
    next_action.ruleset                  = {byte_rs_hi, byte_rs_lo};
  end

  // registered so the action outputs come from flops; spare byte unused
  always_ff @(posedge clk) begin
    if (rst) begin
      action <= '0;
    end else begin
      action <= next_action;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      read_complete  <= `AES_RST_DONE;
      write_complete <= `AES_RST_DONE;
    end else begin
      read_complete  <= rd_done;
      write_complete <= wr_done;
    end
  end

  // ----------------------------------------
  // read-back, one cycle after the strobe
  // ----------------------------------------
  wire [7:0] status_byte;
  assign status_byte = {5'h00, busy, wr_done, rd_done};

  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = `AES_RST_UNMAPPED;
    case (1'b1)
      hit_prio:    next_rdata = byte_prio;
      hit_remark:  next_rdata = byte_remark;
      hit_spare:   next_rdata = byte_spare;
      hit_fwd:     next_rdata = byte_fwd;
      hit_rs_hi:   next_rdata = byte_rs_hi;
      hit_rs_lo:   next_rdata = byte_rs_lo;
      hit_bsel_hi: next_rdata = bsel_hi;
      hit_bsel_lo: next_rdata = bsel_lo;
      hit_status:  next_rdata = status_byte;
      default:     next_rdata = `AES_RST_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= `AES_RST_UNMAPPED;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= `AES_RST_UNMAPPED;
    end
  end

endmodule : aes_staging_regs

//--- verification/aes_staging_regs_props.sv
`timescale 1ns/100ps

// ----------------------------------------
// port checker
// ----------------------------------------
module aes_staging_regs_props
  import aes_pkg::*;
#(
  parameter int ADDR_W  = 8,
  parameter int N_BYTES = 6
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_write,
  input wire logic              reg_read,
  input wire logic [7:0]        reg_rdata,
  input wire logic              xfer_write,
  input wire aes_tbl_req_t      tbl_req,
  input wire aes_tbl_rsp_t      tbl_rsp,
  input wire aes_action_t       action,
  input wire logic              read_complete,
  input wire logic              write_complete
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      rev8[i] = v[7-i];
  endfunction : rev8

  wire idle = read_complete && write_complete && !tbl_req.start && !tbl_rsp.done;

  sequence s_wr(logic [7:0] a);
    reg_write && reg_addr == a && !tbl_rsp.done;
  endsequence
  sequence s_go;
    reg_write && reg_addr == 8'h11 && idle;
  endsequence

  a_prio_byte: assert property (s_wr(8'h0A) |-> ##2 {action.remark_priority_enable,
    action.remark_priority[2:1]} == $past(reg_wdata[2:0], 2)) else $error("priority byte decode");
  a_remark_low: assert property (s_wr(8'h0B) |-> ##2
    action.remark_priority[0] == $past(reg_wdata[7], 2)) else $error("remark low bit");
  a_fwd_map: assert property (s_wr(8'h0D) |-> ##2
    action.forward_ports == $past(reg_wdata[5:0], 2)) else $error("forward map");
  a_start_low: assert property (s_go |=> tbl_req.start) else $error("no start");
  a_start_pulse: assert property (tbl_req.start |=> !tbl_req.start) else $error("start long");
  a_sel_low: assert property (s_go |=>
    tbl_req.byte_sel[15:8] == rev8($past(reg_wdata))) else $error("low select map");
  a_sel_high: assert property (reg_write && reg_addr == 8'h10 ##1 s_go |=>
    tbl_req.byte_sel[7:0] == rev8($past(reg_wdata, 2))) else $error("high select map");
  a_read_wait: assert property (tbl_req.start && !tbl_req.write |=> !read_complete)
    else $error("read status high");
  a_read_done: assert property (tbl_rsp.done && !read_complete |-> ##2 read_complete)
    else $error("read status stuck");
  a_write_wait: assert property (tbl_req.start && tbl_req.write |=> !write_complete)
    else $error("write status high");
  a_write_done: assert property (tbl_rsp.done && !write_complete |-> ##2 write_complete)
    else $error("write status stuck");
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00) else $error("read data stale");
  a_spare_keep: assert property (s_wr(8'h0C) ##1 reg_read && reg_addr == 8'h0C |=>
    reg_rdata == $past(reg_wdata, 2)) else $error("spare readback");
endmodule : aes_staging_regs_props

//--- verification/aes_staging_regs_tb_top.sv
`timescale 1ns/100ps

module aes_staging_regs_tb_top
  import aes_pkg::*;
;
  logic         clk;
  logic         rst;
  logic [7:0]   reg_addr;
  logic [7:0]   reg_wdata;
  logic         reg_write;
  logic         reg_read;
  logic [7:0]   reg_rdata;
  logic         xfer_write;
  aes_tbl_req_t tbl_req;
  aes_tbl_rsp_t tbl_rsp;
  aes_action_t  action;
  logic         read_complete;
  logic         write_complete;
  int           failures;
  int           comparisons;
  int           cycles = 0;
  logic [7:0]   stg [6];

  aes_staging_regs DUT (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .xfer_write(xfer_write), .tbl_req(tbl_req), .tbl_rsp(tbl_rsp), .action(action),
    .read_complete(read_complete), .write_complete(write_complete)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(string what, logic [47:0] seen, logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_read  <= 1'b0;
    reg_addr  <= a;
    reg_wdata <= d;
    if (a >= 8'h0A && a <= 8'h0F) stg[a - 8'h0A] = d;
  endtask : wr

  task automatic idle();
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read  <= 1'b0;
    #1;
  endtask : idle

  task automatic rd(logic [7:0] a, logic [7:0] e, string what);
    @(posedge clk);
    reg_read  <= 1'b1;
    reg_write <= 1'b0;
    reg_addr  <= a;
    @(posedge clk);
    reg_read  <= 1'b0;
    #1 chk(what, reg_rdata, e);
  endtask : rd

  task automatic rd_all();
    for (int i = 0; i < 6; i++)
      rd(8'h0A + 8'(i), stg[i], "staging byte");
  endtask : rd_all

  task automatic pulse_done(logic [47:0] d);
    @(posedge clk);
    tbl_rsp.done  <= 1'b1;
    tbl_rsp.rdata <= d;
    @(posedge clk);
    tbl_rsp.done  <= 1'b0;
    tbl_rsp.rdata <= ~d;
    @(posedge clk);
    #1;
  endtask : pulse_done

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int a = 10; a < 18; a++)
      rd(8'(a), 8'h00, "reset byte");
    rd(8'h13, 8'h03, "reset status");
    rd(8'h20, 8'h00, "unmapped");
  endtask : t_reset

  task automatic t_fields();
    wr(8'h0A, 8'h07);
    wr(8'h0B, 8'hBF);
    wr(8'h0D, 8'hC5);
    wr(8'h0E, 8'h12);
    wr(8'h0F, 8'h34);
    wr(8'h0C, 8'hA5);
    rd(8'h0C, 8'hA5, "spare byte");
    chk("action one", action, {2'h0, 3'h0, 1'b1, 3'h7, 2'h1, 6'h05, 16'h1234});
    rd(8'h0B, 8'hBF, "remark byte");
    rd(8'h0D, 8'hC5, "forward byte");
    wr(8'h0A, 8'hC9);
    wr(8'h0B, 8'h40);
    idle();
    @(posedge clk);
    #1 chk("action two", action, {2'h3, 3'h1, 1'b0, 3'h2, 2'h2, 6'h05, 16'h1234});
  endtask : t_fields

  task automatic t_write_xfer();
    @(posedge clk);
    xfer_write <= 1'b1;
    wr(8'h10, 8'h81);
    wr(8'h11, 8'h21);
    idle();
    chk("start", tbl_req.start, 1);
    chk("byte select", tbl_req.byte_sel, 16'h8481);
    chk("direction", tbl_req.write, 1);
    chk("write data", tbl_req.wdata, {stg[0], stg[1], stg[2], stg[3], stg[4], stg[5]});
    wr(8'h11, 8'hFF);
    idle();
    chk("refused start", tbl_req.start, 0);
    chk("write pending", write_complete, 0);
    rd(8'h13, 8'h05, "write status");
    pulse_done(48'h0);
    chk("write done", write_complete, 1);
    rd_all();
    rd(8'h11, 8'hFF, "select low kept");
  endtask : t_write_xfer

  task automatic t_read_xfer();
    @(posedge clk);
    xfer_write <= 1'b0;
    pulse_done(48'hFFFF_FFFF_FFFF);
    chk("idle done", read_complete, 1);
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h05);
    idle();
    chk("read select", tbl_req.byte_sel, 16'hA000);
    @(posedge clk);
    #1 chk("read pending", read_complete, 0);
    rd(8'h13, 8'h06, "read status");
    pulse_done(48'h1122_3344_5566);
    chk("read done", read_complete, 1);
    stg[3] = 8'h44;
    stg[5] = 8'h66;
    rd_all();
  endtask : t_read_xfer

  // ----------------------------------------
  // verdict and run control
  // ----------------------------------------
  task automatic wrap_up();
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    rst = 1'b1;
    {reg_read, reg_write, xfer_write} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    tbl_rsp = '0;
    failures = 0;
    comparisons = 0;
    for (int i = 0; i < 6; i++)
      stg[i] = 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_write_xfer();
    t_read_xfer();
    wrap_up();
  end
endmodule : aes_staging_regs_tb_top

bind aes_staging_regs aes_staging_regs_props #(.ADDR_W(ADDR_W), .N_BYTES(N_BYTES)) u_props (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .xfer_write(xfer_write), .tbl_req(tbl_req),
  .tbl_rsp(tbl_rsp), .action(action), .read_complete(read_complete),
  .write_complete(write_complete)
);
